// File: arg_ramp_top.sv
// Purpose: Analog ramp generator core with its APB register file.
// Assumes: One 100 MHz clock; control bits are written by software or driving logic.
// Notes: The ramp advances on a 100 ms tick from an internal divider.
`timescale 1ns/1ps
`default_nettype none
`include "arg_regs.svh"
module arg_ramp_top #(
   parameter int unsigned TICK_CYCLES = `ARG_TICK_CYCLES
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Ramp results.
   output var arg_pkg::arg_level_t o_current_level,
   output var arg_pkg::arg_out_t o_scaled_analog_out
);
   import arg_pkg::*;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic ctrl_en;
   logic ctrl_sel;
   logic ctrl_stop;
   arg_level_t target_level_one;
   arg_level_t target_level_two;
   arg_level_t maximum_limit;
   arg_level_t start_stop_offset;
   arg_level_t rate;
   arg_level_t gain;
   arg_level_t offset;
   arg_state_e state;
   arg_level_t level;
   logic [23:0] tick_cnt;
   logic tick;
   logic en_seen;
   logic stop_seen;
   logic en_rise;
   logic stop_rise;
   logic stop_cmd;
   arg_level_t ss_level;
   arg_level_t idle_level;
   arg_level_t target;
   arg_level_t step;
   arg_level_t run_next;
   arg_level_t stop_next;
   logic acc_first;
   logic wr_commit;
   logic addr_ok;
   logic [31:0] rd_data;
   arg_level_t wr_val;
   arg_scale_if scl ();

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------

   // Bounds a written value to the range the parameter accepts.
   function automatic arg_level_t clamp_range(input arg_level_t v, input arg_level_t lo, input arg_level_t hi);
      arg_level_t r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // Moves cur by at most step toward tgt and lands exactly on it.
   function automatic arg_level_t step_toward(input arg_level_t cur, input arg_level_t tgt, input arg_level_t stp);
      logic signed [16:0] d;
      arg_level_t r;
      d = {tgt[15], tgt} - {cur[15], cur};
      r = tgt;
      if (d > 17'(stp)) begin
         r = 16'(cur + stp);
      end else if (d < -17'(stp)) begin
         r = 16'(cur - stp);
      end
      return r;
   endfunction

   // Caps a level at the maximum limit.
   function automatic arg_level_t cap_max(input arg_level_t v, input arg_level_t lim);
      return (v > lim) ? lim : v;
   endfunction

   // ----------------------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------------------

   // The access phase always takes one wait state, so decode sees stable inputs.
   assign acc_first = i_psel & i_penable & ~o_pready;
   assign wr_commit = i_psel & i_penable & o_pready & i_pwrite;
   assign wr_val = i_pwdata[15:0];

   // Address decode and read mux; unmapped reads return zero.
   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h00000000;
      case (i_paddr)
         `ARG_ADDR_CTRL: rd_data = {29'h00000000, ctrl_stop, ctrl_sel, ctrl_en};
         `ARG_ADDR_LEVEL_ONE: rd_data = 32'(target_level_one);
         `ARG_ADDR_LEVEL_TWO: rd_data = 32'(target_level_two);
         `ARG_ADDR_MAX_LIMIT: rd_data = 32'(maximum_limit);
         `ARG_ADDR_START_STOP: rd_data = 32'(start_stop_offset);
         `ARG_ADDR_RATE: rd_data = 32'(rate);
         `ARG_ADDR_GAIN: rd_data = 32'(gain);
         `ARG_ADDR_OFFSET: rd_data = 32'(offset);
         `ARG_ADDR_STATUS: rd_data = {29'h00000000, state};
         `ARG_ADDR_LEVEL: rd_data = 32'(level);
         `ARG_ADDR_OUT: rd_data = {17'h00000, o_scaled_analog_out};
         default: addr_ok = 1'b0;
      endcase
   end

   // Handshake outputs, all registered; pready is high for exactly one cycle.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else begin
         o_pready <= acc_first;
         o_pslverr <= acc_first & ~addr_ok;
         o_prdata <= (acc_first & ~i_pwrite) ? rd_data : 32'h00000000;
      end
   end

   // Writes land on the edge that sees pready; out-of-range values are clamped.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_en <= 1'b0;
         ctrl_sel <= 1'b0;
         ctrl_stop <= 1'b0;
         target_level_one <= `ARG_RST_LEVEL_ONE;
         target_level_two <= `ARG_RST_LEVEL_TWO;
         maximum_limit <= `ARG_RST_MAX_LIMIT;
         start_stop_offset <= `ARG_RST_START_STOP;
         rate <= `ARG_RST_RATE;
         gain <= `ARG_RST_GAIN;
         offset <= `ARG_RST_OFFSET;
      end else if (wr_commit) begin
         case (i_paddr)
            `ARG_ADDR_CTRL: begin
               ctrl_en <= i_pwdata[`ARG_CTRL_EN];
               ctrl_sel <= i_pwdata[`ARG_CTRL_SEL];
               ctrl_stop <= i_pwdata[`ARG_CTRL_STOP];
            end
            `ARG_ADDR_LEVEL_ONE: target_level_one <= clamp_range(wr_val, `ARG_LEVEL_MIN, `ARG_LEVEL_MAX);
            `ARG_ADDR_LEVEL_TWO: target_level_two <= clamp_range(wr_val, `ARG_LEVEL_MIN, `ARG_LEVEL_MAX);
            `ARG_ADDR_MAX_LIMIT: maximum_limit <= clamp_range(wr_val, `ARG_LEVEL_MIN, `ARG_LEVEL_MAX);
            `ARG_ADDR_START_STOP: start_stop_offset <= clamp_range(wr_val, `ARG_ZERO, `ARG_LEVEL_MAX);
            `ARG_ADDR_RATE: rate <= clamp_range(wr_val, `ARG_RATE_MIN, `ARG_RATE_MAX);
            `ARG_ADDR_GAIN: gain <= clamp_range(wr_val, `ARG_ZERO, `ARG_GAIN_MAX);
            `ARG_ADDR_OFFSET: offset <= clamp_range(wr_val, -`ARG_OFFSET_MAX, `ARG_OFFSET_MAX);
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Update tick
   // ----------------------------------------------------------------------------

   // Divider that yields a one-cycle enable every 100 ms.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt <= 24'h000000;
         tick <= 1'b0;
      end else if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
         tick_cnt <= 24'h000000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 24'h000001;
         tick <= 1'b0;
      end
   end

   // Inputs are sampled on the tick so a short glitch between ticks is not an edge.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         en_seen <= 1'b0;
         stop_seen <= 1'b0;
      end else if (tick) begin
         en_seen <= ctrl_en;
         stop_seen <= ctrl_stop;
      end
   end

   assign en_rise = tick & ctrl_en & ~en_seen;
   assign stop_rise = tick & ctrl_stop & ~stop_seen;

   // ----------------------------------------------------------------------------
   // Level arithmetic
   // ----------------------------------------------------------------------------

   // Start/stop, idle and target levels are capped by the limit; the stop ramp step toward ss_level is not.
   assign ss_level = cap_max(16'(offset + start_stop_offset), maximum_limit);
   assign idle_level = cap_max(offset, maximum_limit);
   assign target = cap_max(ctrl_sel ? target_level_two : target_level_one, maximum_limit);

   // Per-tick step is a tenth of the rate; slow rates still move one unit a tick.
   assign step = (rate < 16'(`ARG_TICKS_PER_S)) ? 16'sh0001 : 16'(rate / 16'(`ARG_TICKS_PER_S));
   assign run_next = cap_max(step_toward(level, target, step), maximum_limit);
   assign stop_next = step_toward(level, ss_level, step);
   assign stop_cmd = (state == ARG_STOP_RAMP) || (state == ARG_STOP_HOLD) || (state == ARG_STOPPED);

   // ----------------------------------------------------------------------------
   // Ramp sequencer
   // ----------------------------------------------------------------------------

   // Enable low overrides all states at once; the tick gates every ramp move.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ARG_IDLE;
         level <= `ARG_ZERO;
      end else if (!ctrl_en) begin
         level <= idle_level;
         if (stop_cmd && ctrl_stop) begin
            state <= ARG_STOPPED;
         end else begin
            state <= ARG_IDLE;
         end
      end else begin
         case (state)
            ARG_IDLE: begin
               level <= idle_level;
               if (en_rise) begin
                  level <= ss_level;
                  state <= ARG_START_HOLD;
               end
            end
            ARG_START_HOLD: begin
               if (stop_rise) begin
                  level <= stop_next;
                  state <= ARG_STOP_RAMP;
               end else if (tick) begin
                  level <= run_next;
                  state <= ARG_RUN;
               end
            end
            ARG_RUN: begin
               if (stop_rise) begin
                  level <= stop_next;
                  state <= (stop_next == ss_level) ? ARG_STOP_HOLD : ARG_STOP_RAMP;
               end else if (tick) begin
                  level <= run_next;
               end
            end
            ARG_STOP_RAMP: begin
               if (tick) begin
                  level <= stop_next;
                  if (stop_next == ss_level) begin
                     state <= ARG_STOP_HOLD;
                  end
               end
            end
            ARG_STOP_HOLD: begin
               if (tick) begin
                  level <= idle_level;
                  state <= ARG_STOPPED;
               end
            end
            ARG_STOPPED: begin
               level <= idle_level;
            end
            default: begin
               level <= idle_level;
               state <= ARG_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Output scaling
   // ----------------------------------------------------------------------------

   // Scaler restarts after every result so the output tracks level and settings.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         scl.start <= 1'b1;
      end else begin
         scl.start <= scl.done;
      end
   end

   assign scl.level = level;
   assign scl.offset = offset;
   assign scl.gain = gain[9:0];

   arg_scaler u_scaler (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .scl(scl.calc)
   );

   // Results are registered here so the output pins come from flops.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_scaled_analog_out <= 15'h0000;
         o_current_level <= `ARG_ZERO;
      end else begin
         o_current_level <= level;
         if (scl.done) begin
            o_scaled_analog_out <= scl.result;
         end
      end
   end
endmodule
`default_nettype wire

// File: arg_regs.svh
// Purpose: Register map, field positions, reset values and timing counts of the analog ramp generator.
// Assumes: APB slave with 32-bit data words and a 100 MHz clock.
// Notes: Levels are signed 16-bit engineering units; gain is held in hundredths.
`ifndef ARG_REGS_SVH
`define ARG_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ARG_ADDR_CTRL 8'h00
`define ARG_ADDR_LEVEL_ONE 8'h04
`define ARG_ADDR_LEVEL_TWO 8'h08
`define ARG_ADDR_MAX_LIMIT 8'h0C
`define ARG_ADDR_START_STOP 8'h10
`define ARG_ADDR_RATE 8'h14
`define ARG_ADDR_GAIN 8'h18
`define ARG_ADDR_OFFSET 8'h1C
`define ARG_ADDR_STATUS 8'h20
`define ARG_ADDR_LEVEL 8'h24
`define ARG_ADDR_OUT 8'h28

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define ARG_CTRL_EN 0
`define ARG_CTRL_SEL 1
`define ARG_CTRL_STOP 2

// ----------------------------------------------------------------------------
// Value ranges and reset values
// ----------------------------------------------------------------------------
`define ARG_LEVEL_MIN 16'shD8F0
`define ARG_LEVEL_MAX 16'sh4E20
`define ARG_OFFSET_MAX 16'sh2710
`define ARG_ZERO 16'sh0000
`define ARG_RATE_MIN 16'sh0001
`define ARG_RATE_MAX 16'sh2710
`define ARG_GAIN_MAX 16'sh03E8
`define ARG_GAIN_ONE 16'h0064
`define ARG_OUT_MAX 15'h7FFF
`define ARG_RST_LEVEL_ONE 16'sh0000
`define ARG_RST_LEVEL_TWO 16'sh0000
`define ARG_RST_MAX_LIMIT 16'sh4E20
`define ARG_RST_START_STOP 16'sh0000
`define ARG_RST_RATE 16'sh0064
`define ARG_RST_GAIN 16'sh0064
`define ARG_RST_OFFSET 16'sh0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ARG_TICK_MS 100
`define ARG_CLK_KHZ 100000
`define ARG_TICK_CYCLES (`ARG_TICK_MS * `ARG_CLK_KHZ)
`define ARG_TICKS_PER_S (1000 / `ARG_TICK_MS)

`endif

// File: arg_pkg.sv
// Purpose: Shared types of the analog ramp generator.
// Assumes: Levels fit a signed 16-bit word.
// Notes: Constants live in the register header.
package arg_pkg;
   typedef logic signed [15:0] arg_level_t;
   typedef logic [14:0] arg_out_t;
   typedef enum logic [2:0] {
      ARG_IDLE,
      ARG_START_HOLD,
      ARG_RUN,
      ARG_STOP_RAMP,
      ARG_STOP_HOLD,
      ARG_STOPPED
   } arg_state_e;
endpackage

// File: arg_scale_if.sv
// Purpose: Carrier between the ramp core and its output scaler.
// Assumes: One clock domain.
// Notes: Operands are sampled on start; done is a one-cycle pulse with result.
`timescale 1ns/1ps
`default_nettype none
interface arg_scale_if;
   import arg_pkg::*;
   logic start;
   arg_level_t level;
   arg_level_t offset;
   logic [9:0] gain;
   logic done;
   arg_out_t result;
   modport ctrl (output start, level, offset, gain, input done, result);
   modport calc (input start, level, offset, gain, output done, result);
endinterface
`default_nettype wire

// File: arg_scaler.sv
// Purpose: Scales the current level to the analog output by a serial divider.
// Assumes: Gain in hundredths, 0 to 1000.
// Notes: Takes 22 cycles per divided result; zero gain saturates the output when level is above offset (otherwise the result is zero).
`timescale 1ns/1ps
`default_nettype none
`include "arg_regs.svh"
module arg_scaler (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Operands and result.
   arg_scale_if.calc scl
);
   import arg_pkg::*;

   logic busy;
   logic [4:0] iter;
   logic [21:0] quo;
   logic [10:0] rem;
   logic [9:0] den;
   logic [10:0] rem_sh;
   logic [21:0] quo_nx;
   logic signed [16:0] diff;

   // Difference of level and offset, one bit wider so it cannot wrap.
   assign diff = {scl.level[15], scl.level} - {scl.offset[15], scl.offset};
   assign rem_sh = {rem[9:0], quo[21]};
   assign quo_nx = {quo[20:0], rem_sh >= {1'b0, den}};

   // Restoring division: a serial loop costs time, which the 100 ms tick has plenty of.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy <= 1'b0;
         iter <= 5'h00;
         quo <= 22'h000000;
         rem <= 11'h000;
         den <= 10'h000;
         scl.done <= 1'b0;
         scl.result <= 15'h0000;
      end else if (!busy) begin
         scl.done <= 1'b0;
         if (scl.start) begin
            if (diff <= 17'sh00000) begin
               scl.result <= 15'h0000;
               scl.done <= 1'b1;
            end else if (scl.gain == 10'h000) begin
               scl.result <= `ARG_OUT_MAX;
               scl.done <= 1'b1;
            end else begin
               quo <= 22'(diff[15:0]) * 22'(`ARG_GAIN_ONE);
               rem <= 11'h000;
               den <= scl.gain;
               iter <= 5'h00;
               busy <= 1'b1;
            end
         end
      end else begin
         rem <= quo_nx[0] ? rem_sh - {1'b0, den} : rem_sh;
         quo <= quo_nx;
         iter <= iter + 5'h01;
         if (iter == 5'h15) begin
            busy <= 1'b0;
            scl.done <= 1'b1;
            // The last quotient bit is only in quo_nx here; clamp it to the output range.
            scl.result <= (|quo_nx[21:15]) ? `ARG_OUT_MAX : quo_nx[14:0];
         end
      end
   end

endmodule
`default_nettype wire

// File: arg_ramp_chk.sv
// Purpose: Port-level checks of the analog ramp generator.
// Assumes: One clock domain; bound to every instance of the top module.
// Notes: Tick spacing ignores level moves to or from zero, where enable or offset writes act at once.
`timescale 1ns/1ps
`default_nettype none
module arg_ramp_chk #(
   parameter int unsigned TICK_CYCLES = 50
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Ramp results.
   input wire arg_pkg::arg_level_t o_current_level
);
   import arg_pkg::*;
   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   int unsigned gap;
   // Cycles since the level last moved; a counter keeps the long tick span cheap to check.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap <= '0;
      end else if ($changed(o_current_level)) begin
         gap <= '0;
      end else begin
         gap <= gap + 32'h1;
      end
   end
   sequence acc_first;
      $rose(i_penable) && i_psel;
   endsequence
   sequence ready_late;
      !o_pready ##1 o_pready;
   endsequence
   pready_wait_a: assert property (acc_first |-> ready_late) else $error("ready not after one wait state");
   pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
   slverr_ready_a: assert property (o_pslverr |-> o_pready && i_psel && i_penable) else $error("error without ready");
   rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000) else $error("read data outside answer");
   map_ok_a: assert property (o_pready && i_paddr <= 8'h28 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
      else $error("error on mapped address");
   map_err_a: assert property (o_pready && i_paddr > 8'h28 |-> o_pslverr) else $error("no error on unmapped address");
   level_cap_a: assert property (o_current_level <= 16'sh4E20) else $error("level above limit");
   level_floor_a: assert property (o_current_level >= 16'shD8F0) else $error("level below range");
   tick_space_a: assert property ($changed(o_current_level) && o_current_level != 16'sh0000 &&
      $past(o_current_level) != 16'sh0000 |-> gap >= TICK_CYCLES - 1) else $error("level moved between ticks");
endmodule
bind arg_ramp_top arg_ramp_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_current_level(o_current_level));
`default_nettype wire

// File: arg_drv.sv
// Purpose: Driving logic in front of the ramp block, as an APB master.
// Assumes: Transfers are started right after a rising edge.
// Notes: Released address and data lines show inverted values so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module arg_drv (
   // Clock.
   input wire logic i_clk,
   // APB master.
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata,
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr
);
   // ----------------------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------------------
   // Idle bus at time zero.
   initial begin
      o_psel = 1'h0;
      o_penable = 1'h0;
      o_pwrite = 1'h0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0000_0000;
   end
   // One transfer; control bits and target levels come from here.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge i_clk);
      o_psel <= 1'h1;
      o_pwrite <= wr;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'h1;
      // Waits as long as the slave needs; only the bench watchdog ends a hang.
      do begin
         @(posedge i_clk);
      end while (i_pready !== 1'h1);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'h0;
      o_penable <= 1'h0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// File: tb_analog_ramp_generator.sv
// Purpose: Self-checking bench of the analog ramp generator.
// Assumes: A short tick of 50 cycles stands for the 100 ms update.
// Notes: Scenarios run in order and each leaves the block where the next expects it.
`timescale 1ns/1ps
`default_nettype none
module tb_analog_ramp_generator;
   import arg_pkg::*;
   // ----------------------------------------------------------------------------
   // Bench
   // ----------------------------------------------------------------------------
   localparam int TICK = 50;
   logic i_clk = 1'h0;
   logic i_rst = 1'h1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   arg_level_t lvl;
   arg_out_t aout;
   int num_errors = 0;
   int samples_checked = 0;
   always #5 i_clk = ~i_clk;
   arg_ramp_top #(.TICK_CYCLES(TICK)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_current_level(lvl), .o_scaled_analog_out(aout));
   arg_drv drv (.i_clk(i_clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
      .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      drv.xfer(1'h1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      drv.xfer(1'h0, a, 32'h0000_0000, q, e);
   endtask
   // Writes a value and reads back what the register kept.
   task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [15:0] exp);
      logic [31:0] q;
      logic e;
      wr(a, d);
      rd(a, q, e);
      chk(q[15:0], exp);
   endtask
   // Waits for the next level move, bounded by three ticks, and counts the cycles.
   task automatic next_lvl(output logic [15:0] v, output int n);
      arg_level_t p;
      p = lvl;
      for (n = 0; n < 3 * TICK; n++) begin
         @(posedge i_clk);
         if (lvl !== p) break;
      end
      v = lvl;
   endtask
   task automatic steps(input int from, input int by, input int cnt);
      logic [15:0] v;
      int n;
      for (int i = 1; i <= cnt; i++) begin
         next_lvl(v, n);
         chk(v, 16'(from + i * by));
      end
   endtask
   task automatic hold(input int t, input logic [15:0] exp);
      repeat (t * TICK) @(posedge i_clk);
      chk(lvl, exp);
   endtask
   task automatic settle_out(input logic [15:0] exp);
      repeat (60) @(posedge i_clk);
      chk({1'h0, aout}, exp);
   endtask
   task automatic t_reset();
      logic [31:0] q;
      logic e;
      logic [15:0] exp [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0064, 16'h0064, 16'h0000,
                                16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 11; i++) begin
         rd(8'(i * 4), q, e);
         chk(q[15:0], exp[i]);
         chk({15'h0000, e}, 16'h0000);
      end
      rd(8'h2C, q, e);
      chk({15'h0000, e}, 16'h0001);
      chk(q[15:0], 16'h0000);
      wrd(8'h24, 32'h0000_0123, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_start();
      logic [31:0] q;
      logic e;
      logic [15:0] v;
      int n;
      wr(8'h04, 32'h0000_01F4);
      wr(8'h08, 32'hFFFF_FF38);
      wr(8'h10, 32'h0000_0064);
      wr(8'h14, 32'h0000_03E8);
      wr(8'h00, 32'h0000_0001);
      next_lvl(v, n);
      chk(v, 16'h0064);
      rd(8'h20, q, e);
      chk(q[15:0], 16'h0001);
      next_lvl(v, n);
      chk(v, 16'h00C8);
      steps(32'h0000_00C8, 32'h0000_0064, 3);
      hold(2, 16'h01F4);
      wr(8'h00, 32'h0000_0003);
      steps(32'h0000_01F4, -32'sh0000_0064, 7);
      hold(2, 16'hFF38);
      $display("test start and select done");
   endtask
   task automatic t_stop();
      logic [31:0] q;
      logic e;
      logic [15:0] v;
      int n;
      wr(8'h00, 32'h0000_0007);
      steps(-32'sh0000_00C8, 32'h0000_0064, 3);
      next_lvl(v, n);
      chk(v, 16'h0000);
      chk({15'h0000, n >= TICK - 1 && n <= TICK + 1}, 16'h0001);
      wr(8'h00, 32'h0000_0001);
      hold(3, 16'h0000);
      rd(8'h20, q, e);
      chk(q[15:0], 16'h0005);
      wr(8'h00, 32'h0000_0000);
      hold(1, 16'h0000);
      wr(8'h00, 32'h0000_0001);
      next_lvl(v, n);
      chk(v, 16'h0064);
      $display("test stop done");
   endtask
   task automatic t_disable();
      logic [31:0] q;
      logic e;
      logic [15:0] v;
      int n;
      next_lvl(v, n);
      chk(v, 16'h00C8);
      wr(8'h00, 32'h0000_0000);
      repeat (3) @(posedge i_clk);
      chk(lvl, 16'h0000);
      rd(8'h20, q, e);
      chk(q[15:0], 16'h0000);
      hold(1, 16'h0000);
      $display("test disable done");
   endtask
   task automatic t_limits();
      wr(8'h0C, 32'h0000_012C);
      wr(8'h00, 32'h0000_0001);
      steps(32'h0000_0000, 32'h0000_0064, 3);
      hold(2, 16'h012C);
      wr(8'h00, 32'h0000_0000);
      wrd(8'h0C, 32'h0000_4E20, 16'h4E20);
      wrd(8'h04, 32'h0000_7530, 16'h4E20);
      wrd(8'h14, 32'h0000_0000, 16'h0001);
      wrd(8'h18, 32'h0000_07D0, 16'h03E8);
      wrd(8'h10, 32'h0000_7530, 16'h4E20);
      $display("test limits done");
   endtask
   task automatic t_scale();
      logic [15:0] v;
      int n;
      wr(8'h1C, 32'h0000_03E8);
      wr(8'h10, 32'h0000_0000);
      wr(8'h18, 32'h0000_00C8);
      wr(8'h04, 32'h0000_0BB8);
      wr(8'h14, 32'h0000_2710);
      hold(1, 16'h03E8);
      settle_out(16'h0000);
      wr(8'h00, 32'h0000_0001);
      next_lvl(v, n);
      chk(v, 16'h07D0);
      settle_out(16'h01F4);
      next_lvl(v, n);
      chk(v, 16'h0BB8);
      settle_out(16'h03E8);
      wr(8'h18, 32'h0000_03E8);
      settle_out(16'h00C8);
      wr(8'h18, 32'h0000_0000);
      settle_out(16'h7FFF);
      $display("test scaling done");
   endtask
   // Cuts a hang short well beyond the planned run of a few thousand cycles.
   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'h0;
      t_reset();
      t_start();
      t_stop();
      t_disable();
      t_limits();
      t_scale();
      give_verdict();
   end
endmodule
`default_nettype wire
